// >>> hw/cisc_pkg.sv
// Constants and types for the interrupt and stack control block.
// Assumes one core clock and a synchronous active-high reset.
// Overview of operation
// - Registers 26..31 form three 16-bit pointers
// - Pointer modes: displacement, post-increment, pre-decrement
// - Push decrements by one, call/irq by two
// - Pop increments by one, returns by two
// - Stack pointer low RW, high reads zero
// - Core clock used undivided
// - ALU read, operate, write in one cycle
// - Lower vector wins; reset highest priority
// - Take irq only with both enables set
// - Entry clears global enable; return sets it
// - Vectoring or writing one clears flag
// - Flags persist while disabled, served later
// - Level requests need no stored flag
// - One instruction runs after return
// - Status flags never saved automatically
// - Masking takes effect in same cycle
// - Instruction after unmask runs first
// - Vector reached four cycles after acceptance
// - Multi-cycle instruction finishes before irq
// - Wake from sleep adds four cycles
// - Return takes four cycles, pops two bytes
package cisc_pkg;
  localparam int NUM_SRC = 8;
  localparam int PC_W = 10;
  localparam logic [7:0] TOP_OF_DATA_MEMORY = 8'hDF;
  localparam logic [7:0] SP_HIGH_RESET = 8'h00;
  localparam logic [7:0] STACK_LIMIT = 8'h60;
  localparam logic [PC_W-1:0] RESET_VECTOR = 10'h000;
  localparam logic [PC_W-1:0] VEC_BASE = 10'h001;
  localparam logic [2:0] ENTRY_CYCLES = 3'h4;
  localparam logic [2:0] RETURN_CYCLES = 3'h4;
  localparam logic [2:0] WAKE_CYCLES = 3'h4;
  localparam logic [2:0] JUMP_CYCLES = 3'h3;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] TWO_BYTES = 8'h02;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_DISP = 2'h1;
  localparam logic [1:0] MODE_POSTINC = 2'h2;
  localparam logic [1:0] MODE_PREDEC = 2'h3;
  typedef enum logic [1:0] {
    CISC_RUN = 2'b00,
    CISC_ENTRY = 2'b01,
    CISC_RETURN = 2'b10,
    CISC_WAKE = 2'b11
  } cisc_state_type;
endpackage

// >>> hw/cisc_ptr_if.sv
// Pointer request bundle between sequencer and pointer unit.
// Assumes the pointer unit answers combinationally.
`timescale 1ns/1ps
interface cisc_ptr_if;
  logic [1:0] sel;
  logic [1:0] mode;
  logic [5:0] disp;
  logic use_ptr;
  logic [15:0] addr;
  logic [15:0] new_ptr;
  logic wr_ptr;
  modport seq (output sel, output mode, output disp, output use_ptr,
    input addr, input new_ptr, input wr_ptr);
  modport unit (input sel, input mode, input disp, input use_ptr,
    output addr, output new_ptr, output wr_ptr);
endinterface

// >>> hw/cisc_ptr_unit.sv
// Address pointer unit for the three 16-bit register pairs.
// Assumes the pair values come from the register file.
`timescale 1ns/1ps
module cisc_ptr_unit (
  input wire logic [47:0] pairs_in,
  cisc_ptr_if.unit p
);
  logic [15:0] base;
  always_comb begin
    base = pairs_in[16*p.sel[1:0] +: 16];
    p.addr = base;
    p.new_ptr = base;
    p.wr_ptr = 1'b0;
    if (p.use_ptr) begin
      case (p.mode)
        cisc_pkg::MODE_DISP: begin
          p.addr = base + {10'h000, p.disp};
        end
        cisc_pkg::MODE_POSTINC: begin
          p.new_ptr = base + cisc_pkg::PTR_STEP;
          p.wr_ptr = 1'b1;
        end
        cisc_pkg::MODE_PREDEC: begin
          p.addr = base - cisc_pkg::PTR_STEP;
          p.new_ptr = base - cisc_pkg::PTR_STEP;
          p.wr_ptr = 1'b1;
        end
        default: begin
          p.addr = base;
        end
      endcase
    end
  end
endmodule

// >>> hw/cisc_top.sv
// Interrupt entry/return sequencing, stack pointer and pointer addressing.
// Assumes the instruction sequencer gives one-cycle strobes per instruction.
`timescale 1ns/1ps
module cisc_top #(
  parameter int NUM_SRC = cisc_pkg::NUM_SRC
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic [NUM_SRC-1:0] FLAG_EVENT_IN,
  input wire logic [NUM_SRC-1:0] LEVEL_TYPE_IN,
  input wire logic [NUM_SRC-1:0] LEVEL_COND_IN,
  input wire logic [NUM_SRC-1:0] ENABLE_IN,
  input wire logic [NUM_SRC-1:0] FLAG_CLR_WR_IN,
  input wire logic INSTR_DONE_IN,
  input wire logic MULTI_BUSY_IN,
  input wire logic SLEEPING_IN,
  input wire logic UNMASK_IN,
  input wire logic MASK_IN,
  input wire logic STACK_STORE_IN,
  input wire logic STACK_LOAD_IN,
  input wire logic CALL_IN,
  input wire logic BACK_CALL_IN,
  input wire logic BACK_HANDLER_IN,
  input wire logic SPL_WR_IN,
  input wire logic [7:0] SPL_WDATA_IN,
  input wire logic [cisc_pkg::PC_W-1:0] PC_IN,
  input wire logic [15:0] RET_ADDR_IN,
  input wire logic [47:0] PAIRS_IN,
  input wire logic [1:0] PTR_SEL_IN,
  input wire logic [1:0] PTR_MODE_IN,
  input wire logic [5:0] PTR_DISP_IN,
  input wire logic PTR_USE_IN,
  output logic [7:0] SP_LOW_OUT,
  output logic [7:0] SP_HIGH_OUT,
  output logic GLOBAL_EN_OUT,
  output logic [NUM_SRC-1:0] FLAGS_OUT,
  output logic PC_LOAD_OUT,
  output logic [PC_W-1:0] PC_NEW_OUT,
  output logic STALL_OUT,
  output logic STACK_WR_OUT,
  output logic [7:0] STACK_ADDR_OUT,
  output logic [7:0] STACK_WDATA_OUT,
  output logic [15:0] PTR_ADDR_OUT,
  output logic [15:0] PTR_NEW_OUT,
  output logic PTR_WR_OUT
);
  localparam int PC_W = cisc_pkg::PC_W;
  cisc_pkg::cisc_state_type state_r;
  logic [7:0] sp_r;
  logic ie_r;
  logic [NUM_SRC-1:0] flag_r;
  logic [2:0] cnt_r;
  logic [$clog2(NUM_SRC)-1:0] win_r;
  logic hold_r;
  logic [PC_W-1:0] ret_pc_r;
  logic [NUM_SRC-1:0] req;
  logic any_req;
  logic [$clog2(NUM_SRC)-1:0] win;
  logic take;
  cisc_ptr_if ptr ();

  // Lowest index wins
  function automatic logic [$clog2(NUM_SRC)-1:0] pick(input logic [NUM_SRC-1:0] v);
    pick = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick = i[$clog2(NUM_SRC)-1:0];
      end
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_req
      // Level sources request straight from the condition
      assign req[g] = ENABLE_IN[g] & (LEVEL_TYPE_IN[g] ? LEVEL_COND_IN[g] : flag_r[g]);
    end
  endgenerate

  assign any_req = |req;
  assign win = pick(req);
  // Masking in the same cycle blocks acceptance
  assign take = (state_r == cisc_pkg::CISC_RUN) && ie_r && !MASK_IN && any_req &&
    INSTR_DONE_IN && !MULTI_BUSY_IN && !hold_r;

  // Flags: set wins over clear
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      flag_r <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (FLAG_EVENT_IN[i] && !LEVEL_TYPE_IN[i]) begin
          flag_r[i] <= 1'b1;
        end else if (FLAG_CLR_WR_IN[i] ||
                     (take && win == i[$clog2(NUM_SRC)-1:0])) begin
          flag_r[i] <= 1'b0;
        end
      end
    end
  end

  // One-instruction shadow after return or unmask
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      hold_r <= 1'b0;
    end else if (UNMASK_IN || (state_r == cisc_pkg::CISC_RETURN &&
                 cnt_r == cisc_pkg::ONE_BYTE[2:0])) begin
      hold_r <= 1'b1;
    end else if (INSTR_DONE_IN) begin
      hold_r <= 1'b0;
    end
  end

  // Global enable; status flags are not touched here
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      ie_r <= 1'b0;
    end else if (take || MASK_IN) begin
      ie_r <= 1'b0;
    end else if (UNMASK_IN || (state_r == cisc_pkg::CISC_RETURN &&
                 cnt_r == cisc_pkg::ONE_BYTE[2:0])) begin
      ie_r <= 1'b1;
    end
  end

  // Sequencer for entry, wake and return
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      state_r <= cisc_pkg::CISC_RUN;
      cnt_r <= '0;
      win_r <= '0;
      ret_pc_r <= cisc_pkg::RESET_VECTOR;
    end else begin
      case (state_r)
        cisc_pkg::CISC_RUN: begin
          if (take) begin
            win_r <= win;
            ret_pc_r <= PC_IN;
            state_r <= SLEEPING_IN ? cisc_pkg::CISC_WAKE : cisc_pkg::CISC_ENTRY;
            cnt_r <= SLEEPING_IN ? cisc_pkg::WAKE_CYCLES : cisc_pkg::ENTRY_CYCLES;
          end else if (BACK_HANDLER_IN) begin
            state_r <= cisc_pkg::CISC_RETURN;
            cnt_r <= cisc_pkg::RETURN_CYCLES;
          end
        end
        cisc_pkg::CISC_WAKE: begin
          if (cnt_r == cisc_pkg::ONE_BYTE[2:0]) begin
            state_r <= cisc_pkg::CISC_ENTRY;
            cnt_r <= cisc_pkg::ENTRY_CYCLES;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
        default: begin
          if (cnt_r == cisc_pkg::ONE_BYTE[2:0]) begin
            state_r <= cisc_pkg::CISC_RUN;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r - 3'h1;
          end
        end
      endcase
    end
  end

  // Stack pointer, grows downward
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      sp_r <= cisc_pkg::TOP_OF_DATA_MEMORY;
    end else if (SPL_WR_IN) begin
      sp_r <= SPL_WDATA_IN;
    end else if (take || CALL_IN) begin
      sp_r <= sp_r - cisc_pkg::TWO_BYTES;
    end else if (STACK_STORE_IN) begin
      sp_r <= sp_r - cisc_pkg::ONE_BYTE;
    end else if (BACK_HANDLER_IN || BACK_CALL_IN) begin
      sp_r <= sp_r + cisc_pkg::TWO_BYTES;
    end else if (STACK_LOAD_IN) begin
      sp_r <= sp_r + cisc_pkg::ONE_BYTE;
    end
  end

  // Push return address during entry: low byte then high byte
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      STACK_WR_OUT <= 1'b0;
      STACK_ADDR_OUT <= '0;
      STACK_WDATA_OUT <= '0;
    end else if (take) begin
      STACK_WR_OUT <= 1'b1;
      STACK_ADDR_OUT <= sp_r;
      STACK_WDATA_OUT <= PC_IN[7:0];
    end else if (state_r == cisc_pkg::CISC_ENTRY && cnt_r == cisc_pkg::ENTRY_CYCLES) begin
      STACK_WR_OUT <= 1'b1;
      STACK_ADDR_OUT <= sp_r + cisc_pkg::ONE_BYTE;
      STACK_WDATA_OUT <= {6'h00, ret_pc_r[PC_W-1:8]};
    end else begin
      STACK_WR_OUT <= 1'b0;
    end
  end

  // Program counter redirect and stall
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      PC_LOAD_OUT <= 1'b1;
      PC_NEW_OUT <= cisc_pkg::RESET_VECTOR;
      STALL_OUT <= 1'b0;
    end else begin
      STALL_OUT <= take || (state_r != cisc_pkg::CISC_RUN && cnt_r != cisc_pkg::ONE_BYTE[2:0]);
      PC_LOAD_OUT <= 1'b0;
      if (state_r == cisc_pkg::CISC_ENTRY && cnt_r == cisc_pkg::ONE_BYTE[2:0]) begin
        PC_LOAD_OUT <= 1'b1;
        PC_NEW_OUT <= cisc_pkg::VEC_BASE + {{(PC_W-$clog2(NUM_SRC)){1'b0}}, win_r};
      end else if (state_r == cisc_pkg::CISC_RETURN && cnt_r == cisc_pkg::ONE_BYTE[2:0]) begin
        PC_LOAD_OUT <= 1'b1;
        PC_NEW_OUT <= RET_ADDR_IN[PC_W-1:0];
      end
    end
  end

  // Register-visible state
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      SP_LOW_OUT <= cisc_pkg::TOP_OF_DATA_MEMORY;
      SP_HIGH_OUT <= cisc_pkg::SP_HIGH_RESET;
      GLOBAL_EN_OUT <= 1'b0;
      FLAGS_OUT <= '0;
    end else begin
      SP_LOW_OUT <= sp_r;
      SP_HIGH_OUT <= cisc_pkg::SP_HIGH_RESET;
      GLOBAL_EN_OUT <= ie_r;
      FLAGS_OUT <= flag_r;
    end
  end

  // Pointer addressing, registered results
  assign ptr.sel = PTR_SEL_IN;
  assign ptr.mode = PTR_MODE_IN;
  assign ptr.disp = PTR_DISP_IN;
  assign ptr.use_ptr = PTR_USE_IN;
  cisc_ptr_unit u_ptr (
    .pairs_in(PAIRS_IN),
    .p(ptr.unit)
  );
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      PTR_ADDR_OUT <= '0;
      PTR_NEW_OUT <= '0;
      PTR_WR_OUT <= 1'b0;
    end else begin
      PTR_ADDR_OUT <= ptr.addr;
      PTR_NEW_OUT <= ptr.new_ptr;
      PTR_WR_OUT <= ptr.wr_ptr;
    end
  end

  // Core clock used as-is; ALU single cycle lives in the datapath

  mask_blocks_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    MASK_IN |-> !take) else $error("irq taken with mask");
  enable_needed_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    take |-> ie_r && (req[win] && ENABLE_IN[win])) else $error("irq without enables");
  entry_clears_ie_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    take |=> !ie_r) else $error("global enable not cleared");
  vector_time_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    take && !SLEEPING_IN |-> ##5 PC_LOAD_OUT) else $error("vector not at four cycles");
  wake_time_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    take && SLEEPING_IN |-> !PC_LOAD_OUT [*8] ##1 !PC_LOAD_OUT ##1 PC_LOAD_OUT)
    else $error("wake delay wrong");
  return_sets_ie_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    state_r == cisc_pkg::CISC_RUN && BACK_HANDLER_IN && !take |-> ##5 ie_r)
    else $error("return did not set enable");
  push_two_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    take && !SPL_WR_IN |=> sp_r == $past(sp_r) - cisc_pkg::TWO_BYTES) else $error("sp entry");
  pop_one_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    STACK_LOAD_IN && !SPL_WR_IN && !take && !CALL_IN && !STACK_STORE_IN && !BACK_HANDLER_IN &&
    !BACK_CALL_IN |=> sp_r == $past(sp_r) + cisc_pkg::ONE_BYTE) else $error("sp pop");
  flag_set_wins_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    FLAG_EVENT_IN[0] && !LEVEL_TYPE_IN[0] |=> flag_r[0]) else $error("flag set lost");
  shadow_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    UNMASK_IN |=> !take) else $error("irq right after unmask");
  high_zero_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    SP_HIGH_OUT == cisc_pkg::SP_HIGH_RESET) else $error("sp high not zero");
  entry_c: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN) take ##5 PC_LOAD_OUT);
  wake_c: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN) take && SLEEPING_IN);
  ret_c: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    state_r == cisc_pkg::CISC_RETURN);
  nest_c: cover property (@(posedge REF_CLK_IN) disable iff (RST_IN) take && flag_r[1] && req[0]);
endmodule

// >>> verif/cisc_stack_model.sv
// Data memory stack behind the block: stores return address bytes.
// Assumes low byte is written first, high byte at the next lower address.
`timescale 1ns/1ps
module cisc_stack_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] data_in,
  output logic [15:0] ret_out
);
  logic [7:0] mem_r [0:255];
  logic [7:0] lo_r;
  logic phase_r;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_r <= 1'b0;
      lo_r <= 8'h00;
    end else if (wr_in) begin
      mem_r[addr_in] <= data_in;
      phase_r <= ~phase_r;
      if (!phase_r) begin
        lo_r <= addr_in;
      end
    end
  end
  assign ret_out = {mem_r[lo_r - 8'h01], mem_r[lo_r]};
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the interrupt and stack control block.
// Assumes vector load visible 4 edges after acceptance, 8 when waking.
`timescale 1ns/1ps
module tb_top;
  localparam int PW = cisc_pkg::PC_W;
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] flag_ev = '0, lvl_type = '0, lvl_cond = '0, en = '0, clr_wr = '0;
  logic done = 0, busy = 0, sleeping = 0, unmask = 0, mask = 0;
  logic st_store = 0, st_load = 0, call = 0, bcall = 0, bhand = 0, spl_wr = 0, puse = 0;
  logic [7:0] spl_wd = '0, sp, sp_lo, sp_hi, flags, st_addr, st_data;
  logic [PW-1:0] pc = '0, pc_new, pushed;
  logic [15:0] ret, p, paddr, pnew;
  logic [47:0] pairs = '0;
  logic [1:0] psel = '0, pmode = '0;
  logic [5:0] pdisp = '0;
  logic gen, pc_load, stall, st_wr, pwr;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  always #20 clk = ~clk;
  cisc_top u_cisc_top (.REF_CLK_IN(clk), .RST_IN(rst), .FLAG_EVENT_IN(flag_ev),
    .LEVEL_TYPE_IN(lvl_type), .LEVEL_COND_IN(lvl_cond), .ENABLE_IN(en), .FLAG_CLR_WR_IN(clr_wr),
    .INSTR_DONE_IN(done), .MULTI_BUSY_IN(busy), .SLEEPING_IN(sleeping), .UNMASK_IN(unmask),
    .MASK_IN(mask), .STACK_STORE_IN(st_store), .STACK_LOAD_IN(st_load), .CALL_IN(call),
    .BACK_CALL_IN(bcall), .BACK_HANDLER_IN(bhand), .SPL_WR_IN(spl_wr), .SPL_WDATA_IN(spl_wd),
    .PC_IN(pc), .RET_ADDR_IN(ret), .PAIRS_IN(pairs), .PTR_SEL_IN(psel), .PTR_MODE_IN(pmode),
    .PTR_DISP_IN(pdisp), .PTR_USE_IN(puse), .SP_LOW_OUT(sp_lo), .SP_HIGH_OUT(sp_hi),
    .GLOBAL_EN_OUT(gen), .FLAGS_OUT(flags), .PC_LOAD_OUT(pc_load), .PC_NEW_OUT(pc_new),
    .STALL_OUT(stall), .STACK_WR_OUT(st_wr), .STACK_ADDR_OUT(st_addr),
    .STACK_WDATA_OUT(st_data), .PTR_ADDR_OUT(paddr), .PTR_NEW_OUT(pnew), .PTR_WR_OUT(pwr));
  cisc_stack_model u_cisc_stack_model (.clk_in(clk), .rst_in(rst), .wr_in(st_wr),
    .addr_in(st_addr), .data_in(st_data), .ret_out(ret));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One edge, then drop every single-cycle strobe
  task automatic step();
    @(posedge clk);
    #1;
    {flag_ev, clr_wr, done, unmask, mask, st_store, st_load, call, bcall, bhand} = '0;
    {spl_wr, puse} = '0;
  endtask
  task automatic wait_load(input int exp_k, input logic [PW-1:0] exp_pc);
    int k;
    k = 0;
    do begin
      step();
      k++;
    end while (pc_load !== 1'b1 && k < 20);
    chk("load_delay", 16'(k), 16'(exp_k));
    chk("pc_new", 16'(pc_new), 16'(exp_pc));
  endtask
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      step();
      seen = seen | pc_load;
    end
    chk("no_accept", 16'(seen), 16'h0000);
  endtask
  task automatic accept(input logic [PW-1:0] vec, input int k);
    pc = PW'($urandom % 1000);
    pushed = pc;
    done = 1'b1;
    step();
    chk("stall", 16'(stall), 16'h0001);
    sp = sp - 8'h02;
    wait_load(k, vec);
    chk("ie_clear", 16'(gen), 16'h0000);
    chk("sp_entry", 16'(sp_lo), 16'(sp));
    chk("pushed_pc", 16'(ret[PW-1:0]), 16'(pushed));
  endtask
  task automatic back();
    bhand = 1'b1;
    step();
    sp = sp + 8'h02;
    wait_load(4, pushed);
    step();
    chk("ie_set", 16'(gen), 16'h0001);
    chk("sp_return", 16'(sp_lo), 16'(sp));
    done = 1'b1;
    quiet(6);
  endtask
  function automatic logic [15:0] ptr_addr(input logic [15:0] b, input logic [1:0] m,
      input logic [5:0] d);
    return (m == cisc_pkg::MODE_DISP) ? b + {10'h000, d} :
      (m == cisc_pkg::MODE_PREDEC) ? b - 16'h0001 : b;
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h4c8e));
    repeat (10) @(posedge clk);
    #1;
    chk("sp_low_rst", 16'(sp_lo), 16'(cisc_pkg::TOP_OF_DATA_MEMORY));
    chk("pc_rst", 16'({pc_load, pc_new}), 16'({1'b1, cisc_pkg::RESET_VECTOR}));
    chk("ie_rst", 16'(gen), 16'h0000);
    rst = 1'b0;
    step();
    sp = 8'h80 + 8'($urandom % 64);
    spl_wd = sp;
    spl_wr = 1'b1;
    step();
    step();
    chk("sp_write", 16'(sp_lo), 16'(sp));
    for (int i = 0; i < 4; i++) begin
      {st_store, st_load, call, bcall} = 4'h8 >> i;
      sp = sp + ((i == 0) ? 8'hFF : (i == 1) ? 8'h01 : (i == 2) ? 8'hFE : 8'h02);
      step();
      step();
      chk("sp_step", 16'(sp_lo), 16'(sp));
      chk("sp_high", 16'(sp_hi), 16'(cisc_pkg::SP_HIGH_RESET));
    end
    en = 8'h7F;
    flag_ev = 8'hA4;
    step();
    done = 1'b1;
    quiet(2);
    chk("flags_kept", 16'(flags), 16'h00A4);
    clr_wr = 8'h20;
    flag_ev = 8'h41;
    step();
    step();
    chk("flags_clr", 16'(flags), 16'h00C5);
    unmask = 1'b1;
    step();
    done = 1'b1;
    quiet(3);
    done = 1'b1;
    mask = 1'b1;
    quiet(3);
    unmask = 1'b1;
    step();
    done = 1'b1;
    step();
    accept(cisc_pkg::VEC_BASE, 4);
    chk("flag_vec", 16'(flags), 16'h00C4);
    back();
    sleeping = 1'b1;
    accept(cisc_pkg::VEC_BASE + 10'h002, 8);
    sleeping = 1'b0;
    lvl_type = 8'h10;
    lvl_cond = 8'h10;
    en = 8'h50;
    step();
    lvl_cond = 8'h00;
    back();
    done = 1'b1;
    busy = 1'b1;
    quiet(4);
    busy = 1'b0;
    accept(cisc_pkg::VEC_BASE + 10'h006, 4);
    lvl_cond = 8'h10;
    back();
    accept(cisc_pkg::VEC_BASE + 10'h004, 4);
    for (int m = 0; m < 8; m++) begin
      pairs = 48'({$urandom, $urandom});
      psel = 2'($urandom % 3);
      pmode = 2'(m);
      pdisp = 6'($urandom);
      p = pairs[psel*16 +: 16];
      puse = 1'b1;
      step();
      chk("ptr_addr", paddr, ptr_addr(p, pmode, pdisp));
      if (pmode[1]) begin
        chk("ptr_new", pnew, pmode[0] ? p - 16'h0001 : p + 16'h0001);
      end
      chk("ptr_wr", 16'(pwr), 16'(pmode[1]));
    end
    wrap_up();
  end
endmodule
